// [pkg/rtcal_defs.svh]
// register indices, field positions, reset values and counts for the alarm block
`ifndef RTCAL_DEFS_SVH
`define RTCAL_DEFS_SVH

// register indices; the byte address is four times the index
`define RTCAL_IDX_SEC    5'h01
`define RTCAL_IDX_MIN    5'h02
`define RTCAL_IDX_HOUR   5'h03
`define RTCAL_IDX_DAY    5'h04
`define RTCAL_IDX_DATE   5'h05
`define RTCAL_IDX_MONTH  5'h06
`define RTCAL_IDX_YEAR   5'h07
`define RTCAL_IDX_OUT    5'h08
`define RTCAL_IDX_AMON   5'h0A
`define RTCAL_IDX_ADATE  5'h0B
`define RTCAL_IDX_AHOUR  5'h0C
`define RTCAL_IDX_AMIN   5'h0D
`define RTCAL_IDX_ASEC   5'h0E
`define RTCAL_IDX_FLAGS  5'h0F
`define RTCAL_IDX_IST    5'h10
`define RTCAL_IDX_IMSK   5'h11

// field positions
`define RTCAL_TOP_BIT    7
`define RTCAL_B6_BIT     6
`define RTCAL_IRQ_ALARM  0
`define RTCAL_IRQ_SEC    1

// power-on values
`define RTCAL_RST_ST     1'b0
`define RTCAL_RST_OUT    1'b1
`define RTCAL_RST_LFS    1'b1
`define RTCAL_RST_ALM    8'h00
`define RTCAL_RST_ONE    8'h01

// bcd limits
`define RTCAL_BCD_NINE   4'h9
`define RTCAL_SEC_MAX    8'h59
`define RTCAL_HOUR_MAX   8'h23
`define RTCAL_DAY_MAX    8'h07
`define RTCAL_MON_MAX    8'h12
`define RTCAL_YEAR_MAX   8'h99
`define RTCAL_ZERO       8'h00
`define RTCAL_FEB        5'h02

// line clock edges per second, last count and half count
`define RTCAL_DIV_50     6'h31
`define RTCAL_DIV_60     6'h3B
`define RTCAL_HALF_50    6'h19
`define RTCAL_HALF_60    6'h1E

`endif

// [pkg/rtcal_pkg.sv]
// types shared by the alarm, square-wave and output-pin logic
package rtcal_pkg;

    typedef enum logic [2:0] {
        rpt_sec,
        rpt_min,
        rpt_hour,
        rpt_day,
        rpt_month,
        rpt_year
    } rtcal_rpt_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } rtcal_sync_t;

    typedef struct packed {
        logic        st;
        logic [6:0]  sec;
        logic [6:0]  min;
        logic [5:0]  hour;
        logic [2:0]  day;
        logic        lfs;
        logic [5:0]  date;
        logic [1:0]  cb;
        logic [4:0]  month;
        logic [7:0]  year;
        logic        out;
        logic [7:0]  alm_mon;
        logic [7:0]  alm_date;
        logic [7:0]  alm_hour;
        logic [7:0]  alm_min;
        logic [7:0]  alm_sec;
        logic        af;
        logic [4:0]  ptr;
        logic [5:0]  div;
        logic        eval;
        logic [1:0]  ist;
        logic [1:0]  imsk;
        logic        ack;
        logic [31:0] dat;
        logic        irq;
        logic        irq_pin_oe;
        logic        irq_pin_level;
        logic        sqw_oe;
        logic        sqw_level;
    } rtcal_state_t;

endpackage : rtcal_pkg

// [verilog/rtcal_pin_sync.sv]
// three-stage synchroniser and rising-edge detector for the line clock pin
`timescale 1ns/1ns
module rtcal_pin_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pin,
    output wire logic rise
);
    rtcal_pkg::rtcal_sync_t r;
    rtcal_pkg::rtcal_sync_t next_r;

    always_comb begin
        next_r      = r;
        next_r.s1   = pin;
        next_r.s2   = r.s1;
        next_r.s3   = r.s2;
        next_r.rise = 1'b0;
        if (r.s2 == r.s3) begin
            next_r.level = r.s3;
            next_r.rise  = r.s3 && !r.level;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign rise = r.rise;

endmodule : rtcal_pin_sync

// [verilog/rtcal_top.sv]
// alarm, interrupt, square-wave and output-pin logic with time counters
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "rtcal_defs.svh"
module rtcal_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [6:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output wire logic [31:0] wb_dat_o,
    output wire logic        wb_ack_o,
    output wire logic        irq,
    input  wire logic        line_clk_pin,
    output wire logic        int_out_pin_level,
    output wire logic        int_out_pin_oe,
    input  wire logic        int_out_pin_sense,
    output wire logic        square_wave_pin_level,
    output wire logic        square_wave_pin_oe,
    input  wire logic        square_wave_pin_sense
);
    rtcal_pkg::rtcal_state_t r;
    rtcal_pkg::rtcal_state_t next_r;
    rtcal_pkg::rtcal_rpt_t   mode;
    logic                    line_tick;
    logic                    acc;
    logic                    wr;
    logic                    rd_flags;
    logic [4:0]              idx;
    logic [4:0]              rpt_bits;
    logic                    sec_eq;
    logic                    min_eq;
    logic                    hour_eq;
    logic                    date_eq;
    logic                    mon_eq;
    logic                    alarm_match;
    logic                    hit;

    rtcal_pin_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pin   (line_clk_pin),
        .rise  (line_tick)
    );

    // ----------------------------------------------------------------
    // bcd helpers
    // ----------------------------------------------------------------
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
        logic [8:0] res;
        res = '0;
        if (v >= hi) begin
            res = {1'b1, lo};
        end else if (v[3:0] == `RTCAL_BCD_NINE) begin
            res = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            res = {1'b0, v + 8'h01};
        end
        return res;
    endfunction : bcd_inc

    function automatic logic leap_year(input logic [7:0] y, input logic [1:0] cb);
        logic res;
        res = 1'b0;
        if (y == `RTCAL_ZERO)
            res = (cb == 2'h0);
        else if (y[4])
            res = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        else
            res = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        return res;
    endfunction : leap_year

    function automatic logic [7:0] month_days(input logic [4:0] m, input logic [7:0] y,
                                              input logic [1:0] cb);
        logic [7:0] res;
        res = 8'h31;
        if (m == `RTCAL_FEB)
            res = leap_year(y, cb) ? 8'h29 : 8'h28;
        else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
            res = 8'h30;
        return res;
    endfunction : month_days

    function automatic rtcal_pkg::rtcal_rpt_t rpt_mode(input logic [4:0] m);
        rtcal_pkg::rtcal_rpt_t res;
        case (m)
            5'h1E:   res = rtcal_pkg::rpt_min;
            5'h1C:   res = rtcal_pkg::rpt_hour;
            5'h18:   res = rtcal_pkg::rpt_day;
            5'h10:   res = rtcal_pkg::rpt_month;
            5'h00:   res = rtcal_pkg::rpt_year;
            default: res = rtcal_pkg::rpt_sec;
        endcase
        return res;
    endfunction : rpt_mode

    // ----------------------------------------------------------------
    // bus decode and alarm compare
    // ----------------------------------------------------------------
    assign idx      = wb_adr_i[6:2];
    assign acc      = wb_cyc_i && wb_stb_i && !r.ack;
    assign wr       = acc && wb_we_i && wb_sel_i[0];
    assign rd_flags = acc && !wb_we_i && (idx == `RTCAL_IDX_FLAGS);

    assign rpt_bits = {r.alm_date[`RTCAL_B6_BIT], r.alm_date[`RTCAL_TOP_BIT],
                       r.alm_hour[`RTCAL_TOP_BIT], r.alm_min[`RTCAL_TOP_BIT],
                       r.alm_sec[`RTCAL_TOP_BIT]};
    assign mode     = rpt_mode(rpt_bits);
    assign sec_eq   = r.alm_sec[6:0] == r.sec;
    assign min_eq   = r.alm_min[6:0] == r.min;
    assign hour_eq  = r.alm_hour[5:0] == r.hour;
    assign date_eq  = r.alm_date[5:0] == r.date;
    assign mon_eq   = r.alm_mon[4:0] == r.month;
    assign alarm_match = (mode == rtcal_pkg::rpt_sec) || (sec_eq &&
        ((mode == rtcal_pkg::rpt_min) || (min_eq &&
        ((mode == rtcal_pkg::rpt_hour) || (hour_eq &&
        ((mode == rtcal_pkg::rpt_day) || (date_eq &&
        ((mode == rtcal_pkg::rpt_month) || mon_eq))))))));
    // one compare per seconds update, blocked while pointer sits on flags
    assign hit = r.eval && alarm_match && (r.ptr != `RTCAL_IDX_FLAGS);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [8:0] inc;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [5:0] div_last;
        logic       carry;
        logic       sec_tick;
        inc      = '0;
        wd       = wb_dat_i[7:0];
        rd       = '0;
        div_last = r.lfs ? `RTCAL_DIV_60 : `RTCAL_DIV_50;
        carry    = 1'b0;
        sec_tick = 1'b0;
        next_r   = r;

        // line clock divider gives the one-second tick
        if (line_tick && !r.st) begin
            if (r.div >= div_last) begin
                next_r.div = '0;
                carry      = 1'b1;
            end else begin
                next_r.div = r.div + 6'h01;
            end
        end
        sec_tick    = carry;
        next_r.eval = carry;

        if (carry) begin
            inc        = bcd_inc({1'b0, r.sec}, `RTCAL_ZERO, `RTCAL_SEC_MAX);
            next_r.sec = inc[6:0];
            carry      = inc[8];
        end
        if (carry) begin
            inc        = bcd_inc({1'b0, r.min}, `RTCAL_ZERO, `RTCAL_SEC_MAX);
            next_r.min = inc[6:0];
            carry      = inc[8];
        end
        if (carry) begin
            inc         = bcd_inc({2'h0, r.hour}, `RTCAL_ZERO, `RTCAL_HOUR_MAX);
            next_r.hour = inc[5:0];
            carry       = inc[8];
        end
        if (carry) begin
            inc         = bcd_inc({5'h0, r.day}, `RTCAL_RST_ONE, `RTCAL_DAY_MAX);
            next_r.day  = inc[2:0];
            inc         = bcd_inc({2'h0, r.date}, `RTCAL_RST_ONE,
                                  month_days(r.month, r.year, r.cb));
            next_r.date = inc[5:0];
            carry       = inc[8];
        end
        if (carry) begin
            inc          = bcd_inc({3'h0, r.month}, `RTCAL_RST_ONE, `RTCAL_MON_MAX);
            next_r.month = inc[4:0];
            carry        = inc[8];
        end
        if (carry) begin
            inc         = bcd_inc(r.year, `RTCAL_ZERO, `RTCAL_YEAR_MAX);
            next_r.year = inc[7:0];
            carry       = inc[8];
        end
        if (carry)
            next_r.cb = r.cb + 2'h1;

        // register writes; a write into the clock bank restarts the divider
        if (wr) begin
            if (idx == `RTCAL_IDX_SEC) begin
                next_r.st  = wd[`RTCAL_TOP_BIT];
                next_r.sec = wd[6:0];
                next_r.div = '0;
            end else if (idx == `RTCAL_IDX_MIN) begin
                next_r.min = wd[6:0];
                next_r.div = '0;
            end else if (idx == `RTCAL_IDX_HOUR) begin
                next_r.hour = wd[5:0];
                next_r.div  = '0;
            end else if (idx == `RTCAL_IDX_DAY) begin
                next_r.day = wd[2:0];
                next_r.div = '0;
            end else if (idx == `RTCAL_IDX_DATE) begin
                next_r.lfs  = wd[`RTCAL_TOP_BIT];
                next_r.date = wd[5:0];
                next_r.div  = '0;
            end else if (idx == `RTCAL_IDX_MONTH) begin
                next_r.cb    = {wd[`RTCAL_TOP_BIT], wd[`RTCAL_B6_BIT]};
                next_r.month = wd[4:0];
                next_r.div   = '0;
            end else if (idx == `RTCAL_IDX_YEAR) begin
                next_r.year = wd;
                next_r.div  = '0;
            end else if (idx == `RTCAL_IDX_OUT) begin
                next_r.out = wd[`RTCAL_TOP_BIT];
            end else if (idx == `RTCAL_IDX_AMON) begin
                next_r.alm_mon = wd;
            end else if (idx == `RTCAL_IDX_ADATE) begin
                next_r.alm_date = wd;
            end else if (idx == `RTCAL_IDX_AHOUR) begin
                next_r.alm_hour = wd;
            end else if (idx == `RTCAL_IDX_AMIN) begin
                next_r.alm_min = wd;
            end else if (idx == `RTCAL_IDX_ASEC) begin
                next_r.alm_sec = wd;
            end else if (idx == `RTCAL_IDX_IMSK) begin
                next_r.imsk = wd[1:0];
            end
        end

        // read mux; the flag register drops writes
        if (idx == `RTCAL_IDX_SEC)
            rd = {r.st, r.sec};
        else if (idx == `RTCAL_IDX_MIN)
            rd = {1'b0, r.min};
        else if (idx == `RTCAL_IDX_HOUR)
            rd = {2'h0, r.hour};
        else if (idx == `RTCAL_IDX_DAY)
            rd = {5'h0, r.day};
        else if (idx == `RTCAL_IDX_DATE)
            rd = {r.lfs, 1'b0, r.date};
        else if (idx == `RTCAL_IDX_MONTH)
            rd = {r.cb[1], r.cb[0], 1'b0, r.month};
        else if (idx == `RTCAL_IDX_YEAR)
            rd = r.year;
        else if (idx == `RTCAL_IDX_OUT)
            rd = {r.out, 7'h00};
        else if (idx == `RTCAL_IDX_AMON)
            rd = r.alm_mon;
        else if (idx == `RTCAL_IDX_ADATE)
            rd = r.alm_date;
        else if (idx == `RTCAL_IDX_AHOUR)
            rd = r.alm_hour;
        else if (idx == `RTCAL_IDX_AMIN)
            rd = r.alm_min;
        else if (idx == `RTCAL_IDX_ASEC)
            rd = r.alm_sec;
        else if (idx == `RTCAL_IDX_FLAGS)
            rd = {1'b0, r.af, 6'h00};
        else if (idx == `RTCAL_IDX_IST)
            rd = {6'h00, r.ist};
        else if (idx == `RTCAL_IDX_IMSK)
            rd = {6'h00, r.imsk};

        next_r.ack = acc;
        next_r.dat = (acc && !wb_we_i) ? {24'h000000, rd} : '0;
        if (acc)
            next_r.ptr = idx + 5'h01;

        // clears first so that a same-cycle event wins
        if (rd_flags)
            next_r.af = 1'b0;
        if (hit)
            next_r.af = 1'b1;
        if (acc && !wb_we_i && idx == `RTCAL_IDX_IST)
            next_r.ist = '0;
        if (hit)
            next_r.ist[`RTCAL_IRQ_ALARM] = 1'b1;
        if (sec_tick)
            next_r.ist[`RTCAL_IRQ_SEC] = 1'b1;
        next_r.irq = |(next_r.ist & next_r.imsk);

        // open-drain interrupt/output pin, low when enabled
        next_r.irq_pin_level = 1'b0;
        if (next_r.alm_mon[`RTCAL_TOP_BIT])
            next_r.irq_pin_oe = next_r.af;
        else
            next_r.irq_pin_oe = !next_r.out;

        // 1 Hz square wave, high for the first half of each second
        next_r.sqw_level = 1'b0;
        next_r.sqw_oe    = 1'b0;
        if (next_r.alm_mon[`RTCAL_B6_BIT]) begin
            if (next_r.alm_hour[`RTCAL_B6_BIT]) begin
                next_r.sqw_oe = next_r.div >= (next_r.lfs ? `RTCAL_HALF_60 : `RTCAL_HALF_50);
            end else begin
                next_r.sqw_oe    = 1'b1;
                next_r.sqw_level = next_r.div < (next_r.lfs ? `RTCAL_HALF_60 : `RTCAL_HALF_50);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r          <= '0;
            r.st       <= `RTCAL_RST_ST;
            r.out      <= `RTCAL_RST_OUT;
            r.lfs      <= `RTCAL_RST_LFS;
            r.alm_mon  <= `RTCAL_RST_ALM;
            r.alm_hour <= `RTCAL_RST_ALM;
            r.day      <= 3'h1;
            r.date     <= 6'h01;
            r.month    <= 5'h01;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign wb_dat_o              = r.dat;
    assign wb_ack_o              = r.ack;
    assign irq                   = r.irq;
    assign int_out_pin_level     = r.irq_pin_level;
    assign int_out_pin_oe        = r.irq_pin_oe;
    assign square_wave_pin_level = r.sqw_level;
    assign square_wave_pin_oe    = r.sqw_oe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking dck @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_flag_set;
        ce && r.eval && alarm_match && r.ptr != `RTCAL_IDX_FLAGS |=> r.af;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("alarm flag not set");

    property p_ptr_block;
        ce && r.eval && !r.af && r.ptr == `RTCAL_IDX_FLAGS |=> !r.af;
    endproperty
    a_ptr_block: assert property (p_ptr_block) else $error("flag set on flag ptr");

    property p_ptr_inc;
        ce && wr && idx == `RTCAL_IDX_ASEC |=> r.ptr == `RTCAL_IDX_FLAGS;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not on flags");

    property p_rd_clear;
        ce && rd_flags && r.af && !hit |=> !r.af && wb_ack_o;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("flag read did not clear");

    property p_rd_value;
        ce && rd_flags && r.af |=> wb_dat_o[`RTCAL_B6_BIT] ##1 !wb_ack_o;
    endproperty
    a_rd_value: assert property (p_rd_value) else $error("flag read lost value");

    property p_pin_irq;
        r.alm_mon[`RTCAL_TOP_BIT] |-> int_out_pin_oe == r.af && !int_out_pin_level;
    endproperty
    a_pin_irq: assert property (p_pin_irq) else $error("irq pin mismatch");

    property p_pin_out;
        !r.alm_mon[`RTCAL_TOP_BIT] |-> int_out_pin_oe == !r.out;
    endproperty
    a_pin_out: assert property (p_pin_out) else $error("out pin mismatch");

    property p_sqw_off;
        !r.alm_mon[`RTCAL_B6_BIT] |-> !square_wave_pin_oe && !square_wave_pin_level;
    endproperty
    a_sqw_off: assert property (p_sqw_off) else $error("square wave not off");

    property p_sqw_od;
        r.alm_mon[`RTCAL_B6_BIT] && r.alm_hour[`RTCAL_B6_BIT] |-> !square_wave_pin_level;
    endproperty
    a_sqw_od: assert property (p_sqw_od) else $error("open drain drives high");

    property p_century;
        ce && !wr && r.year == `RTCAL_YEAR_MAX && next_r.year == `RTCAL_ZERO
            |=> r.cb == $past(r.cb) + 2'h1;
    endproperty
    a_century: assert property (p_century) else $error("century did not step");

    property p_af_ro;
        ce && wr && idx == `RTCAL_IDX_FLAGS && !r.af && !hit |=> !r.af;
    endproperty
    a_af_ro: assert property (p_af_ro) else $error("host wrote alarm flag");

endmodule : rtcal_top

// [tb/rtcal_far_side.sv]
// line clock source and pull-up resolution for the pins of the alarm block
`timescale 1ns/1ns
module rtcal_far_side #(
    parameter int HALF_NS = 170
) (
    input  wire logic int_oe,
    input  wire logic int_level,
    input  wire logic sq_oe,
    input  wire logic sq_level,
    output var  logic line_clk,
    output wire logic int_line,
    output wire logic sq_line
);
    // free-running line clock, far above mains rate to keep seconds short
    initial begin
        line_clk = 1'b0;
        forever #(HALF_NS) line_clk = ~line_clk;
    end
    // a released pin floats up to its external pull-up
    assign int_line = int_oe ? int_level : 1'b1;
    assign sq_line  = sq_oe ? sq_level : 1'b1;
endmodule : rtcal_far_side

// [tb/tb.sv]
// self-checking bench for alarm modes, flag clearing, pins and century handling
`timescale 1ns/1ns
module tb;
    localparam int HALF_S = 765;
    localparam int ONE_S  = 510;
    localparam logic [4:0] MODES [6] = '{5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10, 5'h00};
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [6:0]  adr;
    logic [31:0] dat;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq;
    logic        line_clk;
    logic        int_lvl;
    logic        int_oe;
    logic        int_line;
    logic        sq_lvl;
    logic        sq_oe;
    logic        sq_line;
    logic [15:0] q[$];
    logic [4:0]  code;
    logic [39:0] cent [5];
    int          n_fail;
    int          samples_checked;
    int          cyc_cnt;
    int          seed;
    int          hi;
    int          on;

    rtcal_top rtcal_top_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq(irq), .line_clk_pin(line_clk), .int_out_pin_level(int_lvl),
        .int_out_pin_oe(int_oe), .int_out_pin_sense(int_line), .square_wave_pin_level(sq_lvl),
        .square_wave_pin_oe(sq_oe), .square_wave_pin_sense(sq_line));
    rtcal_far_side rtcal_far_side_inst (.int_oe(int_oe), .int_level(int_lvl), .sq_oe(sq_oe),
        .sq_level(sq_lvl), .line_clk(line_clk), .int_line(int_line), .sq_line(sq_line));

    // ----------------------------------------
    // checks and bus cycles
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [4:0] idx, input logic [7:0] d,
                      input logic [7:0] msk, input logic [7:0] exp);
        int n;
        n = 0;
        q.push_back({msk, exp});
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) chk("ack", 1'b0, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [4:0] i, input logic [7:0] d);
        wb(1'b1, i, d, 8'hFF, 8'h00);
    endtask : wr

    task automatic rd(input logic [4:0] i, input logic [7:0] e);
        wb(1'b0, i, 8'h00, 8'hFF, e);
    endtask : rd

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task automatic watch(input int n);
        on = 0;
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            on += (sq_oe === 1'b1);
            hi += (sq_line === 1'b1);
        end
    endtask : watch

    task automatic mode_run(input logic [4:0] c, input logic [7:0] e);
        wr(5'h0E, {c[0], 7'h02});
        wr(5'h0D, {c[1], 7'h00});
        wr(5'h0C, {c[2], 7'h00});
        wr(5'h0B, {c[3], c[4], 6'h01});
        wr(5'h0A, 8'h81);
        wr(5'h01, 8'h00);
        wb(1'b0, 5'h0F, 8'h00, 8'h00, 8'h00);
        wb(1'b0, 5'h0F, 8'h00, 8'h00, 8'h00);
        wt(HALF_S);
        chk("alarm pin", int_line, !e[6]);
        rd(5'h0F, e);
        wt(ONE_S);
        chk("alarm pin", int_oe, 1'b1);
        rd(5'h0F, 8'h40);
        rd(5'h0F, 8'h00);
        chk("pin release", int_oe, 1'b0);
        $display("end of alarm mode %b", c);
    endtask : mode_run

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // scoreboard and timeout
    // ----------------------------------------
    always @(posedge clk) begin : mon
        logic [15:0] nt;
        if (wb_ack_o === 1'b1) begin
            nt = (q.size() > 0) ? q.pop_front() : 16'h00FF;
            chk("read data", {|wb_dat_o[31:8], wb_dat_o[7:0] & nt[15:8]}, {1'b0, nt[7:0]});
        end
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        {rst_n, cyc, stb, we, adr, dat} = '0;
        seed = 25;
        cent = '{40'h1231994181, 40'hD231990181, 40'h02280002A9, 40'h4228004381,
                 40'h0228030381};
        wt(2);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(5'h01, 8'h00);
        rd(5'h08, 8'h80);
        rd(5'h05, 8'h81);
        rd(5'h0A, 8'h00);
        rd(5'h0C, 8'h00);
        chk("pins idle", {int_line, sq_oe}, 2'b10);
        wr(5'h09, 8'hFF);
        rd(5'h09, 8'h00);
        $display("end of reset values");
        for (int i = 0; i < 6; i++) mode_run(MODES[i], (i == 0) ? 8'h40 : 8'h00);
        do code = 5'($random(seed)); while (code inside {5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10, 5'h00});
        mode_run(code, 8'h40);
        wr(5'h0E, 8'h00);
        wr(5'h0D, 8'h00);
        wr(5'h0C, 8'h00);
        wr(5'h0B, 8'h00);
        wb(1'b0, 5'h0F, 8'h00, 8'h00, 8'h00);
        wr(5'h0F, 8'h40);
        wt(HALF_S + ONE_S);
        rd(5'h0F, 8'h00);
        wr(5'h0D, 8'h80);
        wr(5'h0C, 8'h80);
        wr(5'h0B, 8'hC1);
        wb(1'b0, 5'h0F, 8'h00, 8'h00, 8'h00);
        wr(5'h0E, 8'h80);
        wt(HALF_S + ONE_S);
        chk("suppressed pin", int_line, 1'b1);
        rd(5'h0F, 8'h00);
        $display("end of alarm off and suppression");
        wr(5'h11, 8'h00);
        wb(1'b0, 5'h10, 8'h00, 8'h00, 8'h00);
        wt(600);
        chk("masked irq", irq, 1'b0);
        wr(5'h11, 8'h02);
        wt(3);
        chk("irq", irq, 1'b1);
        wb(1'b0, 5'h10, 8'h00, 8'h02, 8'h02);
        wt(3);
        chk("irq cleared", irq, 1'b0);
        wr(5'h0A, 8'h40);
        wr(5'h08, 8'h00);
        wt(2);
        chk("out pin", int_line, 1'b0);
        wr(5'h08, 8'h80);
        wt(2);
        chk("out pin", int_line, 1'b1);
        wr(5'h0C, 8'h00);
        watch(600);
        chk("push-pull", {on == 600, hi > 0 && hi < 600}, 2'b11);
        wr(5'h0C, 8'h40);
        watch(600);
        chk("open drain", {on > 0 && on < 600, on + hi == 600}, 2'b11);
        wr(5'h0A, 8'h00);
        watch(600);
        chk("square off", on, 16'h0000);
        $display("end of interrupt and pin tests");
        foreach (cent[i]) begin
            wr(5'h03, 8'h23);
            wr(5'h02, 8'h59);
            wr(5'h06, cent[i][39:32]);
            wr(5'h05, cent[i][31:24] | 8'h80);
            wr(5'h07, cent[i][23:16]);
            wr(5'h01, 8'h59);
            wt(HALF_S);
            rd(5'h06, cent[i][15:8]);
            rd(5'h05, cent[i][7:0]);
        end
        $display("end of century and leap tests");
        report_and_stop();
    end
endmodule : tb
